/* srp_defs.vh */
// constants for the reset-retention, slumber and phy event counter block
`ifndef SRP_DEFS_VH
`define SRP_DEFS_VH

// register byte addresses, one 32-bit word each
`define SRP_ADDR_STATUS 8'h00
`define SRP_ADDR_FEAT 8'h04
`define SRP_ADDR_PARAM 8'h08
`define SRP_ADDR_SEC 8'h0c
`define SRP_ADDR_LOGCMD 8'h10
`define SRP_ADDR_LOGIDX 8'h14
`define SRP_ADDR_LOGDATA 8'h18
`define SRP_ADDR_IDW76 8'h1c

// status register bit positions
`define SRP_ST_SLUMBER 0
`define SRP_ST_PRESERVE 1
`define SRP_ST_PEC_SUP 2
`define SRP_ST_SNAP 3

// feature register bit positions
`define SRP_FT_WCE 0
`define SRP_FT_RLA 1
`define SRP_FT_REVERT 2
`define SRP_FT_APM 3
`define SRP_FT_DIPM 4
`define SRP_FT_XFER_LSB 8

// log command register bit: clear counters after the snapshot
`define SRP_LOG_CLR 0

// set features subcommand codes
`define SRP_SF_EN 8'h10
`define SRP_SF_DIS 8'h90
`define SRP_SF_CNT_PRESERVE 8'h06
`define SRP_SF_WCE_EN 8'h02
`define SRP_SF_WCE_DIS 8'h82
`define SRP_SF_XFER 8'h03
`define SRP_SF_APM_EN 8'h05
`define SRP_SF_APM_DIS 8'h85
`define SRP_SF_RLA_DIS 8'h55
`define SRP_SF_RLA_EN 8'haa
`define SRP_SF_REV_EN 8'hcc
`define SRP_SF_REV_DIS 8'h66

// power-on defaults of the retained settings
`define SRP_RST_PRESERVE 1'b1
`define SRP_RST_WCE 1'b1
`define SRP_RST_RLA 1'b1
`define SRP_RST_REVERT 1'b0
`define SRP_RST_APM 1'b0
`define SRP_RST_DIPM 1'b0
`define SRP_RST_XFER 8'h00
`define SRP_RST_APM_LVL 8'h00
`define SRP_RST_STBY 8'h00
`define SRP_RST_MULT 8'h00
`define SRP_RST_IDP 8'h00
`define SRP_RST_UNLOCK 3'h5

// identify word 76 with the phy event counter support bit (bit 10)
`define SRP_IDW76 16'h0400

// counter layout: identifiers carry width code 2h (32 bit) in bits 14:12
`define SRP_NCNT 4
`define SRP_CW 32
`define SRP_ID_ICRC 16'h2001
`define SRP_ID_PHYRDY 16'h2009
`define SRP_ID_SIGFIS 16'h200a
`define SRP_ID_NDCRC 16'h2012
// page of 512 bytes read as 256 halfwords; two reserved halfwords lead
`define SRP_PAGE_HW 256
`define SRP_HDR_HW 2

`endif

/* srp_host_model.sv */
// host side model: out-of-band signalling, bist and counted phy events
`timescale 1ns/1ns
`default_nettype none
module srp_host_model
(
   // clock
   input wire clk,
   // events towards the device
   output logic oob_comwake,
   output logic oob_comreset,
   output logic pm_slumber_enter,
   output logic bist_activate,
   output logic [3:0] ev_pulse
);
   initial {bist_activate, pm_slumber_enter, oob_comreset, oob_comwake, ev_pulse} = 8'h00;

   // one-cycle pulses: [7] bist, [6] slumber, [5] comreset, [4] comwake, [3:0] events
   // bist activate is how the host clears the counters
   task fire(input logic [7:0] m);
      @(posedge clk);
      {bist_activate, pm_slumber_enter, oob_comreset, oob_comwake, ev_pulse} <= m;
      @(posedge clk);
      {bist_activate, pm_slumber_enter, oob_comreset, oob_comwake, ev_pulse} <= 8'h00;
   endtask
endmodule
`default_nettype wire

/* srp_top.v */
// slumber state, settings retention across comreset and phy event counters
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "srp_defs.vh"

module srp_top
(
   // clock and power-on reset
   input wire clk,
   input wire rst_b,
   // out-of-band and power management events from the phy, one-cycle pulses
   input wire oob_comwake,
   input wire oob_comreset,
   input wire pm_slumber_enter,
   input wire soft_reset,
   // command layer strobes
   input wire sf_valid,
   input wire [7:0] sf_sub,
   input wire [7:0] sf_count,
   input wire idp_valid,
   input wire [7:0] idp_data,
   input wire stby_valid,
   input wire [7:0] stby_data,
   input wire mult_valid,
   input wire [7:0] mult_data,
   input wire sec_freeze,
   input wire sec_unlock_fail,
   input wire san_freeze,
   input wire bist_activate,
   // counted events, one-cycle pulses: icrc, phyrdy, signature fis, non-data crc
   input wire [3:0] ev_pulse,
   // avalon-mm slave
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg avs_waitrequest,
   output reg [31:0] avs_readdata,
   // link state outputs
   output reg slumber_out,
   output reg hard_reset_pulse
);

   // link power states, one-hot
   localparam ST_ACTIVE = 3'b001;
   localparam ST_SLUMBER = 3'b010;
   localparam ST_HRESET = 3'b100;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg preserve_r;
   reg wce_r;
   reg rla_r;
   reg revert_r;
   reg apm_r;
   reg dipm_r;
   reg [7:0] xfer_r;
   reg [7:0] apm_lvl_r;
   reg [7:0] stby_r;
   reg [7:0] mult_r;
   reg [7:0] idp_r;
   reg sec_frozen_r;
   reg [2:0] unlock_r;
   reg san_frozen_r;
   reg [7:0] log_idx_r;
   reg snap_valid_r;
   reg [`SRP_CW-1:0] cnt_r [0:`SRP_NCNT-1];
   reg [`SRP_CW-1:0] snap_r [0:`SRP_NCNT-1];
   reg [15:0] hw_sel;
   reg [31:0] rd_mux;
   wire hard_reset;
   wire acc_wr;
   wire log_cmd;
   wire cnt_clear;
   wire [15:0] idw76_w;
   integer i;
   integer j;

   // a bus write takes effect only on the edge that completes the handshake
   assign acc_wr = avs_write & ~avs_waitrequest;
   assign log_cmd = acc_wr && (avs_address == `SRP_ADDR_LOGCMD) && avs_byteenable[0];
   // the snapshot is taken before the clear lands, so the page sees old values
   assign cnt_clear = bist_activate | (log_cmd & avs_writedata[`SRP_LOG_CLR]);
   assign hard_reset = (state_r == ST_HRESET);
   // identify word kept whole so the support bit is a plain bit select
   assign idw76_w = `SRP_IDW76;

   // link power state: in slumber only oob wake or reset can move us
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_ACTIVE:
         begin
            if (oob_comreset)
               state_nxt = ST_HRESET;
            else if (pm_slumber_enter)
               state_nxt = ST_SLUMBER;
         end
         ST_SLUMBER:
         begin
            // line patterns of low transition density are ignored here
            if (oob_comreset)
               state_nxt = ST_HRESET;
            else if (oob_comwake)
               state_nxt = ST_ACTIVE;
         end
         ST_HRESET:
         begin
            if (oob_comreset)
               state_nxt = ST_HRESET;
            else
               state_nxt = ST_ACTIVE;
         end
         default:
            state_nxt = ST_ACTIVE;
      endcase
   end

   // state register and link outputs
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= ST_ACTIVE;
         slumber_out <= 1'b0;
         hard_reset_pulse <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         slumber_out <= (state_nxt == ST_SLUMBER);
         hard_reset_pulse <= (state_nxt == ST_HRESET) && (state_r != ST_HRESET);
      end
   end

   // settings: a hard reset without preservation returns all but preserve_r to defaults;
   // a soft reset keeps them, and security state ignores any comreset
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         preserve_r <= `SRP_RST_PRESERVE;
         wce_r <= `SRP_RST_WCE;
         rla_r <= `SRP_RST_RLA;
         revert_r <= `SRP_RST_REVERT;
         apm_r <= `SRP_RST_APM;
         dipm_r <= `SRP_RST_DIPM;
         xfer_r <= `SRP_RST_XFER;
         apm_lvl_r <= `SRP_RST_APM_LVL;
         stby_r <= `SRP_RST_STBY;
         mult_r <= `SRP_RST_MULT;
         idp_r <= `SRP_RST_IDP;
      end
      else if (hard_reset && !preserve_r)
      begin
         // preservation off: comreset behaves as a plain hard reset
         wce_r <= `SRP_RST_WCE;
         rla_r <= `SRP_RST_RLA;
         revert_r <= `SRP_RST_REVERT;
         apm_r <= `SRP_RST_APM;
         dipm_r <= `SRP_RST_DIPM;
         xfer_r <= `SRP_RST_XFER;
         apm_lvl_r <= `SRP_RST_APM_LVL;
         stby_r <= `SRP_RST_STBY;
         mult_r <= `SRP_RST_MULT;
         idp_r <= `SRP_RST_IDP;
      end
      else if (!hard_reset)
      begin
         // preservation on: every listed setting simply holds over comreset
         if (sf_valid)
         begin
            if ((sf_sub == `SRP_SF_EN) || (sf_sub == `SRP_SF_DIS))
            begin
               if (sf_count == `SRP_SF_CNT_PRESERVE)
                  preserve_r <= (sf_sub == `SRP_SF_EN);
               else
                  dipm_r <= (sf_sub == `SRP_SF_EN);
            end
            else if (sf_sub == `SRP_SF_WCE_EN)
               wce_r <= 1'b1;
            else if (sf_sub == `SRP_SF_WCE_DIS)
               wce_r <= 1'b0;
            else if (sf_sub == `SRP_SF_XFER)
               xfer_r <= sf_count;
            else if (sf_sub == `SRP_SF_APM_EN)
            begin
               apm_r <= 1'b1;
               apm_lvl_r <= sf_count;
            end
            else if (sf_sub == `SRP_SF_APM_DIS)
               apm_r <= 1'b0;
            else if (sf_sub == `SRP_SF_RLA_EN)
               rla_r <= 1'b1;
            else if (sf_sub == `SRP_SF_RLA_DIS)
               rla_r <= 1'b0;
            else if (sf_sub == `SRP_SF_REV_EN)
               revert_r <= 1'b1;
            else if (sf_sub == `SRP_SF_REV_DIS)
               revert_r <= 1'b0;
         end
         if (idp_valid)
            idp_r <= idp_data;
         if (stby_valid)
            stby_r <= stby_data;
         if (mult_valid)
            mult_r <= mult_data;
      end
   end

   // security and sanitize state: only power-on clears it, comreset never
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sec_frozen_r <= 1'b0;
         unlock_r <= `SRP_RST_UNLOCK;
         san_frozen_r <= 1'b0;
      end
      else
      begin
         if (sec_freeze)
            sec_frozen_r <= 1'b1;
         if (sec_unlock_fail && (unlock_r != 3'h0))
            unlock_r <= unlock_r - 3'h1;
         if (san_freeze)
            san_frozen_r <= 1'b1;
      end
   end

   // event counters: only power-on, bist and the clearing log read reset them;
   // comreset and soft reset do not reach them. an event in the clear cycle
   // still counts as one, so no event is lost to the clear
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (i = 0; i < `SRP_NCNT; i = i + 1)
            cnt_r[i] <= {`SRP_CW{1'b0}};
      end
      else
      begin
         for (i = 0; i < `SRP_NCNT; i = i + 1)
         begin
            if (cnt_clear)
               cnt_r[i] <= {{(`SRP_CW-1){1'b0}}, ev_pulse[i]};
            else if (ev_pulse[i] && (cnt_r[i] != {`SRP_CW{1'b1}}))
               cnt_r[i] <= cnt_r[i] + {{(`SRP_CW-1){1'b0}}, 1'b1};
         end
      end
   end

   // snapshot for the log page, taken when the log command is written
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (j = 0; j < `SRP_NCNT; j = j + 1)
            snap_r[j] <= {`SRP_CW{1'b0}};
         snap_valid_r <= 1'b0;
      end
      else if (log_cmd)
      begin
         for (j = 0; j < `SRP_NCNT; j = j + 1)
            snap_r[j] <= cnt_r[j];
         snap_valid_r <= 1'b1;
      end
   end

   // log page as halfwords: two reserved, then id, value low, value high per
   // counter, then zero; a zero id marks the end of the list
   always @*
   begin
      hw_sel = 16'h0000;
      if ((log_idx_r >= 8'd2) && (log_idx_r < 8'd14))
      begin
         case (log_idx_r)
            8'd2: hw_sel = `SRP_ID_ICRC;
            8'd3: hw_sel = snap_r[0][15:0];
            8'd4: hw_sel = snap_r[0][31:16];
            8'd5: hw_sel = `SRP_ID_PHYRDY;
            8'd6: hw_sel = snap_r[1][15:0];
            8'd7: hw_sel = snap_r[1][31:16];
            8'd8: hw_sel = `SRP_ID_SIGFIS;
            8'd9: hw_sel = snap_r[2][15:0];
            8'd10: hw_sel = snap_r[2][31:16];
            8'd11: hw_sel = `SRP_ID_NDCRC;
            8'd12: hw_sel = snap_r[3][15:0];
            8'd13: hw_sel = snap_r[3][31:16];
            default: hw_sel = 16'h0000;
         endcase
      end
      // index 14 onward reads zero: terminator and padding to 512 bytes
   end

   // read data decode; unmapped addresses read zero
   always @*
   begin
      rd_mux = 32'h0000_0000;
      if (avs_address == `SRP_ADDR_STATUS)
      begin
         rd_mux[`SRP_ST_SLUMBER] = slumber_out;
         rd_mux[`SRP_ST_PRESERVE] = preserve_r;
         rd_mux[`SRP_ST_PEC_SUP] = idw76_w[10];
         rd_mux[`SRP_ST_SNAP] = snap_valid_r;
      end
      else if (avs_address == `SRP_ADDR_FEAT)
      begin
         rd_mux[`SRP_FT_WCE] = wce_r;
         rd_mux[`SRP_FT_RLA] = rla_r;
         rd_mux[`SRP_FT_REVERT] = revert_r;
         rd_mux[`SRP_FT_APM] = apm_r;
         rd_mux[`SRP_FT_DIPM] = dipm_r;
         rd_mux[`SRP_FT_XFER_LSB+7:`SRP_FT_XFER_LSB] = xfer_r;
      end
      else if (avs_address == `SRP_ADDR_PARAM)
         rd_mux = {idp_r, mult_r, stby_r, apm_lvl_r};
      else if (avs_address == `SRP_ADDR_SEC)
         rd_mux = {24'h000000, 3'h0, san_frozen_r, unlock_r, sec_frozen_r};
      else if (avs_address == `SRP_ADDR_LOGIDX)
         rd_mux = {24'h000000, log_idx_r};
      else if (avs_address == `SRP_ADDR_LOGDATA)
         rd_mux = {16'h0000, hw_sel};
      else if (avs_address == `SRP_ADDR_IDW76)
         rd_mux = {16'h0000, `SRP_IDW76};
   end

   // avalon slave: waitrequest drops for one cycle, one edge after the
   // request is seen; holding it high by default keeps a request from
   // being taken twice
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         log_idx_r <= 8'h00;
      end
      else
      begin
         if ((avs_read || avs_write) && avs_waitrequest)
         begin
            avs_waitrequest <= 1'b0;
            if (avs_read)
               avs_readdata <= rd_mux;
         end
         else
            avs_waitrequest <= 1'b1;
         if (acc_wr && (avs_address == `SRP_ADDR_LOGIDX) && avs_byteenable[0])
            log_idx_r <= avs_writedata[7:0];
      end
   end

endmodule
`default_nettype wire

/* srp_top_asserts.sv */
// checker for the bus handshake and the link state outputs of srp_top
`timescale 1ns/1ns
`default_nettype none
module srp_top_asserts
(
   // clock and power-on reset
   input wire clk,
   input wire rst_b,
   // out-of-band events
   input wire oob_comwake,
   input wire oob_comreset,
   input wire pm_slumber_enter,
   // register bus
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire [31:0] avs_readdata,
   // link state
   input wire slumber_out,
   input wire hard_reset_pulse
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // a request waits exactly one cycle, then waitrequest returns high
   chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   // read data must not move between answers, the master may sample late
   chk_data_stands: assert property (avs_waitrequest |-> $stable(avs_readdata))
      else $error("read data changed without a read answer");
   // entry into slumber from the active state
   chk_slumber_enter: assert property (pm_slumber_enter && !slumber_out && !hard_reset_pulse
      && !oob_comreset && !$past(oob_comreset) |=> slumber_out)
      else $error("slumber not entered");
   chk_slumber_hold: assert property (slumber_out && !oob_comwake && !oob_comreset |=> slumber_out)
      else $error("slumber left without wake or reset");
   chk_wake_exit: assert property (slumber_out && oob_comwake && !oob_comreset
      |=> !slumber_out && !hard_reset_pulse)
      else $error("wake did not return to active");
   chk_comreset_hard: assert property ($rose(oob_comreset) |=> hard_reset_pulse && !slumber_out)
      else $error("comreset did not give a hard reset");
   chk_pulse_single: assert property (hard_reset_pulse |=> !hard_reset_pulse)
      else $error("hard reset pulse longer than one cycle");
   chk_pulse_cause: assert property (hard_reset_pulse |-> $past(oob_comreset))
      else $error("hard reset pulse without comreset");
endmodule
`default_nettype wire

/* tb_srp_top.sv */
// self-checking testbench of srp_top
`timescale 1ns/1ns
`default_nettype none
module tb_srp_top;
   logic clk, rst_b, soft_reset, sf_valid, idp_valid, stby_valid, mult_valid;
   logic sec_freeze, sec_unlock_fail, san_freeze, avs_read, avs_write;
   logic [7:0] sf_sub, sf_count, idp_data, stby_data, mult_data, avs_address;
   logic [31:0] avs_writedata, q;
   logic [3:0] avs_byteenable;
   wire oob_comwake, oob_comreset, pm_slumber_enter, bist_activate;
   wire avs_waitrequest, slumber_out, hard_reset_pulse;
   wire [3:0] ev_pulse;
   wire [31:0] avs_readdata;
   int fails, check_count;

   srp_top u_dut (.clk, .rst_b, .oob_comwake, .oob_comreset, .pm_slumber_enter, .soft_reset,
      .sf_valid, .sf_sub, .sf_count, .idp_valid, .idp_data, .stby_valid, .stby_data,
      .mult_valid, .mult_data, .sec_freeze, .sec_unlock_fail, .san_freeze, .bist_activate,
      .ev_pulse, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_waitrequest, .avs_readdata, .slumber_out, .hard_reset_pulse);
   srp_host_model u_host (.clk, .oob_comwake, .oob_comreset, .pm_slumber_enter,
      .bist_activate, .ev_pulse);

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one avalon access; the request is held until waitrequest is sampled low,
   // with no assumed cycle count: only the watchdog ends a stuck wait
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task rc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), q, e);
   endtask

   task sf(input logic [15:0] sc);
      @(posedge clk);
      sf_valid <= 1'b1;
      sf_sub <= sc[15:8];
      sf_count <= sc[7:0];
      @(posedge clk);
      sf_valid <= 1'b0;
   endtask

   // defaults after power-on, read-only and unmapped places
   task t_defaults;
      rc(8'h00, 32'h6);
      rc(8'h1c, 32'h400);
      bus(1'b1, 8'h04, 32'hffff);
      bus(1'b1, 8'h20, 32'hffff);
      rc(8'h04, 32'h3);
      rc(8'h0c, 32'ha);
      rc(8'h20, 32'h0);
      // a write with byte lane 0 disabled must leave the index alone
      avs_byteenable <= 4'he;
      bus(1'b1, 8'h14, 32'h5);
      avs_byteenable <= 4'hf;
      rc(8'h14, 32'h0);
      bus(1'b1, 8'h14, 32'h5);
      rc(8'h14, 32'h5);
   endtask

   // settings survive comreset while preservation is on, revert when off
   task t_settings;
      logic [15:0] s1 [6] = '{16'h8200, 16'h5500, 16'hcc00, 16'h0580, 16'h0345, 16'h1003};
      logic [15:0] s2 [10] = '{16'h0507, 16'h8500, 16'hcc00, 16'h6600, 16'h8200,
         16'h0200, 16'h5500, 16'haa00, 16'h1001, 16'h9001};
      foreach (s1[i]) sf(s1[i]);
      @(posedge clk);
      idp_valid <= 1'b1;
      stby_valid <= 1'b1;
      mult_valid <= 1'b1;
      idp_data <= 8'h3f;
      stby_data <= 8'h12;
      mult_data <= 8'h10;
      sec_freeze <= 1'b1;
      sec_unlock_fail <= 1'b1;
      san_freeze <= 1'b1;
      @(posedge clk);
      idp_valid <= 1'b0;
      stby_valid <= 1'b0;
      mult_valid <= 1'b0;
      sec_freeze <= 1'b0;
      sec_unlock_fail <= 1'b0;
      san_freeze <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         rc(8'h04, 32'h451c);
         rc(8'h08, 32'h3f101280);
         rc(8'h0c, 32'h19);
         u_host.fire(8'h20);
      end
      sf(16'h9006);
      rc(8'h00, 32'hc);
      u_host.fire(8'h20);
      rc(8'h04, 32'h3);
      rc(8'h08, 32'h0);
      rc(8'h0c, 32'h19);
      sf(16'h1006);
      rc(8'h00, 32'he);
      foreach (s2[i]) sf(s2[i]);
      rc(8'h04, 32'h3);
      rc(8'h08, 32'h7);
   endtask

   // counter page, survival of resets, clear after snapshot and by bist
   task t_counters;
      logic [15:0] e [15] = '{16'h0, 16'h0, 16'h2001, 16'h3, 16'h0, 16'h2009, 16'h1, 16'h0,
         16'h200a, 16'h0, 16'h0, 16'h2012, 16'h2, 16'h0, 16'h0};
      u_host.fire(8'h0b);
      u_host.fire(8'h09);
      u_host.fire(8'h01);
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      u_host.fire(8'h20);
      bus(1'b1, 8'h10, 32'h0);
      foreach (e[i])
      begin
         bus(1'b1, 8'h14, i);
         rc(8'h18, {16'h0, e[i]});
      end
      bus(1'b1, 8'h14, 32'hff);
      rc(8'h18, 32'h0);
      bus(1'b1, 8'h14, 32'h3);
      bus(1'b1, 8'h10, 32'h1);
      rc(8'h18, 32'h3);
      bus(1'b1, 8'h10, 32'h0);
      rc(8'h18, 32'h0);
      u_host.fire(8'h01);
      u_host.fire(8'h80);
      bus(1'b1, 8'h10, 32'h0);
      rc(8'h18, 32'h0);
   endtask

   // slumber held until wake, comreset also leaves it as a hard reset
   task t_slumber;
      u_host.fire(8'h40);
      repeat (6) @(posedge clk);
      rc(8'h00, 32'hf);
      u_host.fire(8'h10);
      #1 chk("slumber", slumber_out, 1'b0);
      u_host.fire(8'h40);
      u_host.fire(8'h20);
      #1 chk("slumber", slumber_out, 1'b0);
      chk("hard reset", hard_reset_pulse, 1'b1);
   endtask

   // power cycle in mid-run: counters cleared, preservation back on
   task t_power;
      u_host.fire(8'h01);
      sf(16'h9006);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rc(8'h00, 32'h6);
      bus(1'b1, 8'h10, 32'h0);
      bus(1'b1, 8'h14, 32'h3);
      rc(8'h18, 32'h0);
   endtask

   task report_and_stop;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end

   initial
   begin
      #200000;
      fails++;
      report_and_stop;
   end

   initial
   begin
      {rst_b, soft_reset, sf_valid, idp_valid, stby_valid, mult_valid} = 6'h0;
      {sec_freeze, sec_unlock_fail, san_freeze, avs_read, avs_write} = 5'h0;
      {sf_sub, sf_count, idp_data, stby_data, mult_data, avs_address} = 48'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      fails = 0;
      check_count = 0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_defaults;
      t_counters;
      t_settings;
      t_slumber;
      t_power;
      report_and_stop;
   end
endmodule

// checker attached to every instance of the top module
bind srp_top srp_top_asserts u_chk (.clk(clk), .rst_b(rst_b), .oob_comwake(oob_comwake),
   .oob_comreset(oob_comreset), .pm_slumber_enter(pm_slumber_enter), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
   .slumber_out(slumber_out), .hard_reset_pulse(hard_reset_pulse));
`default_nettype wire
